// [logic/bcis_pkg.sv]
// Function
// - Byte variant copies source byte to destination while count is nonzero.
// - Both pointers advance by one after every byte moved.
// - Byte count decrements per byte; stops at zero; zero at entry skips.
// - Word variant uses full 16-bit count, otherwise identical.
// - Execution takes 8 states plus 4 states per byte moved.
// - Fixed count holds for on-chip memory; other memory adds access costs.
// - Transfers synchronised to slow peripheral clock may take variable states.
// - Decoder picks instruction group by top bit of second byte upper nibble.
`default_nettype none
package bcis_pkg;
  localparam int unsigned BCIS_SETUP_STATES = 8;
  localparam int unsigned BCIS_BYTE_STATES = 4;
  localparam int unsigned BCIS_INSTR_BYTES = 4;
  localparam logic [7:0] BCIS_OPC_FIRST = 8'h7b;
  localparam logic [15:0] BCIS_COUNT_RST = 16'h0000;
  localparam logic [23:0] BCIS_PTR_RST = 24'h000000;
  typedef enum logic [4:0] {
    BCIS_IDLE = 5'b00001,
    BCIS_SETUP = 5'b00010,
    BCIS_READ = 5'b00100,
    BCIS_WRITE = 5'b01000,
    BCIS_DONE = 5'b10000
  } bcis_state_e;
endpackage
`default_nettype wire

// [logic/bcis_buf2.sv]
`default_nettype none
module bcis_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0] cnt;
  } bcis_buf_s;
  bcis_buf_s st_r;
  bcis_buf_s st_nxt;
  logic push;
  logic pop;

  assign o_ready = (st_r.cnt != 2'h2);
  assign o_valid = (st_r.cnt != 2'h0);
  assign o_data = st_r.mem[0];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb begin
    st_nxt = st_r;
    if (pop) begin
      st_nxt.mem[0] = st_r.mem[1];
    end
    if (push) begin
      if (st_r.cnt == 2'h0 || (st_r.cnt == 2'h1 && pop)) begin
        st_nxt.mem[0] = i_data;
      end else begin
        st_nxt.mem[1] = i_data;
      end
    end
    st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// [logic/bcis_top.sv]
`default_nettype none
module bcis_top
  import bcis_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic [7:0] i_opc_first,
  input wire logic [7:0] i_opc_second,
  input wire logic [15:0] i_word_count_reg,
  input wire logic [23:0] i_source_pointer_reg,
  input wire logic [23:0] i_dest_pointer_reg,
  input wire logic [7:0] i_ccr,
  output logic o_busy,
  output logic o_done,
  output logic o_group_hi,
  output logic o_is_block_copy,
  output logic o_word_variant,
  output logic o_rd_req,
  output logic [23:0] o_rd_addr,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data,
  output logic o_wr_req,
  output logic [23:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  input wire logic i_wr_ack,
  input wire logic i_slow_sync,
  output logic [15:0] o_word_count_reg,
  output logic [23:0] o_source_pointer_reg,
  output logic [23:0] o_dest_pointer_reg,
  output logic [7:0] o_ccr,
  output logic [2:0] o_instr_len,
  output logic [31:0] o_state_count
);
  // ************************************************************
  // State.
  // ************************************************************
  typedef struct packed {
    bcis_state_e st;
    logic word_v;
    logic [15:0] cnt;
    logic [23:0] src;
    logic [23:0] dst;
    logic [7:0] ccr;
    logic rd_out;
    logic [1:0] setup_cnt;
    logic [31:0] states;
    logic done;
    logic [2:0] sync;
  } bcis_s;
  bcis_s s_r;
  bcis_s s_nxt;
  logic [7:0] wr_data;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_accept;
  logic is_copy;
  logic group_hi;
  logic slow_ok;

  assign group_hi = i_opc_second[7];
  assign is_copy = (i_opc_first == BCIS_OPC_FIRST) && group_hi;

  // Peripheral sync strobe passes three flops; counts once the last two are both high.
  assign slow_ok = s_r.sync[1] & s_r.sync[2];

  // ************************************************************
  // Read data buffer.
  // ************************************************************
  bcis_buf2 #(.WIDTH(8)) u_buf (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_valid(i_rd_valid),
    .o_ready(buf_in_ready),
    .i_data(i_rd_data),
    .o_valid(buf_out_valid),
    .i_ready(buf_accept),
    .o_data(wr_data)
  );
  assign buf_accept = (s_r.st == BCIS_WRITE) && i_wr_ack;

  // ************************************************************
  // Sequencer.
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.sync = {s_r.sync[1:0], i_slow_sync};
    if (s_r.st != BCIS_IDLE && s_r.st != BCIS_DONE) begin
      s_nxt.states = s_r.states + 32'h1;
    end
    unique case (s_r.st)
      BCIS_IDLE: begin
        if (i_start && is_copy) begin
          s_nxt.word_v = (i_opc_second[3:0] == 4'h8);
          s_nxt.cnt = (i_opc_second[3:0] == 4'h8) ? i_word_count_reg : {8'h00, i_word_count_reg[7:0]};
          s_nxt.src = i_source_pointer_reg;
          s_nxt.dst = i_dest_pointer_reg;
          s_nxt.ccr = i_ccr;
          s_nxt.setup_cnt = 2'h0;
          s_nxt.states = 32'h1;
          s_nxt.st = BCIS_SETUP;
        end
      end
      BCIS_SETUP: begin
        // Fixed overhead: 8 states total, each setup tick stands for two states.
        s_nxt.setup_cnt = s_r.setup_cnt + 2'h1;
        if (s_r.setup_cnt == 2'(BCIS_SETUP_STATES / 2 - 1)) begin
          s_nxt.st = (s_r.cnt == 16'h0000) ? BCIS_DONE : BCIS_READ;
        end
      end
      BCIS_READ: begin
        // Slow peripheral transfers wait for the sync strobe: variable length.
        // Only the synchronised copy is read; the raw pin would be metastable here.
        if (!s_r.rd_out && buf_in_ready && (slow_ok || !s_r.sync[2])) begin
          s_nxt.rd_out = 1'b1;
        end
        if (s_r.rd_out && i_rd_valid) begin
          s_nxt.rd_out = 1'b0;
          s_nxt.st = BCIS_WRITE;
        end
      end
      BCIS_WRITE: begin
        if (buf_out_valid && i_wr_ack) begin
          s_nxt.src = s_r.src + 24'h1;
          s_nxt.dst = s_r.dst + 24'h1;
          s_nxt.cnt = s_r.cnt - 16'h1;
          s_nxt.st = (s_r.cnt == 16'h0001) ? BCIS_DONE : BCIS_READ;
        end
      end
      BCIS_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.st = BCIS_IDLE;
      end
      default: begin
        s_nxt.st = BCIS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_r <= '{st: BCIS_IDLE, cnt: BCIS_COUNT_RST, src: BCIS_PTR_RST, dst: BCIS_PTR_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************
  assign o_busy = (s_r.st != BCIS_IDLE);
  assign o_done = s_r.done;
  assign o_group_hi = group_hi;
  assign o_is_block_copy = is_copy;
  assign o_word_variant = s_r.word_v;
  assign o_rd_req = s_r.rd_out;
  assign o_rd_addr = s_r.src;
  assign o_wr_req = (s_r.st == BCIS_WRITE) && buf_out_valid;
  assign o_wr_addr = s_r.dst;
  assign o_wr_data = wr_data;
  assign o_word_count_reg = s_r.word_v ? s_r.cnt : {i_word_count_reg[15:8], s_r.cnt[7:0]};
  assign o_source_pointer_reg = s_r.src;
  assign o_dest_pointer_reg = s_r.dst;
  assign o_ccr = s_r.ccr;
  assign o_instr_len = 3'(BCIS_INSTR_BYTES);
  assign o_state_count = s_r.states;
endmodule
`default_nettype wire

// [testbench/bcis_checker.sv]
`default_nettype none
module bcis_checker (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic [7:0] i_opc_second,
  input wire logic [15:0] i_word_count_reg,
  input wire logic i_rd_valid,
  input wire logic i_wr_ack,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_group_hi,
  input wire logic o_is_block_copy,
  input wire logic o_rd_req,
  input wire logic o_wr_req,
  input wire logic [15:0] o_word_count_reg,
  input wire logic [23:0] o_source_pointer_reg,
  input wire logic [23:0] o_dest_pointer_reg,
  input wire logic [7:0] o_ccr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic go;
  logic z;
  logic mv;
  assign go = i_start && !o_busy && o_is_block_copy;
  assign z = (i_opc_second[3:0] == 4'h8) ? i_word_count_reg == 16'h0 : i_word_count_reg[7:0] == 8'h0;
  assign mv = o_wr_req && i_wr_ack;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  AST_RD_HOLD: assert property (o_rd_req && !i_rd_valid |=> o_rd_req) else $error("rd dropped");
  AST_WR_HOLD: assert property (o_wr_req && !i_wr_ack |=> o_wr_req) else $error("wr dropped");
  AST_SRC_INC: assert property (mv |=> o_source_pointer_reg - $past(o_source_pointer_reg) == 24'h1) else $error("src");
  AST_DST_INC: assert property (mv |=> o_dest_pointer_reg - $past(o_dest_pointer_reg) == 24'h1) else $error("dst");
  AST_CNT_DEC: assert property (mv |=> $past(o_word_count_reg[7:0]) - o_word_count_reg[7:0] == 8'h1) else $error("cnt");
  AST_ZERO: assert property (go && z |-> ##6 o_done) else $error("zero skip");
  AST_FIRST_RD: assert property (go && !z |-> ##[6:10] o_rd_req) else $error("no read");
  AST_DONE_1: assert property (o_done |=> !o_done) else $error("done width");
  AST_GROUP: assert property (o_group_hi == i_opc_second[7]) else $error("group");
  AST_CCR: assert property (o_busy |=> $stable(o_ccr)) else $error("ccr");
  cover property (go && z);
  cover property (mv);
  cover property (o_rd_req && !i_rd_valid);
endmodule
bind bcis_top bcis_checker u_chk (.i_clk, .i_srst, .i_start, .i_opc_second, .i_word_count_reg, .i_rd_valid,
  .i_wr_ack, .o_busy, .o_done, .o_group_hi, .o_is_block_copy, .o_rd_req, .o_wr_req, .o_word_count_reg,
  .o_source_pointer_reg, .o_dest_pointer_reg, .o_ccr);
`default_nettype wire

// [testbench/bcis_mem.sv]
`default_nettype none
module bcis_mem (
  input wire logic i_clk,
  input wire logic i_rd_req,
  input wire logic [23:0] i_rd_addr,
  input wire logic i_wr_req,
  input wire logic [1:0] i_lat,
  output var logic o_rd_valid = 1'b0,
  output var logic [7:0] o_rd_data = 8'h00,
  output var logic o_wr_ack = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int w = 0;
  // Data toggles outside a read answer so a stale byte is never mistaken for good.
  always @(negedge i_clk) begin
    o_rd_valid <= 1'b0;
    o_wr_ack <= 1'b0;
    o_rd_data <= ~o_rd_data;
    if ((i_rd_req || i_wr_req) && !o_rd_valid && !o_wr_ack) begin
      w <= w + 1;
      if (w >= i_lat) begin
        w <= 0;
        o_rd_valid <= i_rd_req;
        o_wr_ack <= i_wr_req && !i_rd_req;
        if (i_rd_req) o_rd_data <= i_rd_addr[7:0] ^ 8'h5a;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_block_copy_instruction_sequencer.sv]
`default_nettype none
module tb_block_copy_instruction_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, start = 0, slow = 0, rv, wa, rr, wr, busy, done, gh, cp;
  logic [1:0] lat = 0;
  logic [7:0] op1 = 8'h7b, op2 = 0, ccr = 0, rd, wd, occr;
  logic [2:0] ilen;
  logic [31:0] ost;
  logic [15:0] cnt = 0, ocnt;
  logic [23:0] src = 0, dst = 0, ra, wad, osrc, odst, es, ed;
  logic [31:0] seed = 32'hac77739d, r;
  int error_cnt = 0, n_checks = 0, nw;
  bcis_top DUT (.i_clk(clk), .i_srst(srst), .i_start(start), .i_opc_first(op1), .i_opc_second(op2),
    .i_word_count_reg(cnt), .i_source_pointer_reg(src), .i_dest_pointer_reg(dst), .i_ccr(ccr), .o_busy(busy),
    .o_done(done), .o_group_hi(gh), .o_is_block_copy(cp), .o_word_variant(), .o_rd_req(rr), .o_rd_addr(ra),
    .i_rd_valid(rv), .i_rd_data(rd), .o_wr_req(wr), .o_wr_addr(wad), .o_wr_data(wd), .i_wr_ack(wa),
    .i_slow_sync(slow), .o_word_count_reg(ocnt), .o_source_pointer_reg(osrc), .o_dest_pointer_reg(odst),
    .o_ccr(occr), .o_instr_len(ilen), .o_state_count(ost));
  bcis_mem MEM (.i_clk(clk), .i_rd_req(rr), .i_rd_addr(ra), .i_wr_req(wr), .i_lat(lat), .o_rd_valid(rv),
    .o_rd_data(rd), .o_wr_ack(wa));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic run(input logic [7:0] s2, input logic [15:0] c, input int n);
    int t;
    r = rnd();
    @(negedge clk);
    op2 = s2;
    cnt = c;
    src = r[23:0];
    dst = {r[7:0], r[31:16]};
    ccr = r[15:8];
    es = src;
    ed = dst;
    nw = 0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    chk(n != 0 || t == 5, "zero count timing");
    chk(n != 0 || ost === 32'(bcis_pkg::BCIS_SETUP_STATES / 2 + 1), "setup states");
    chk(ilen === 3'h4, "instr length");
    chk(nw == n && osrc === src + 24'(n) && odst === dst + 24'(n), "bytes moved");
    chk(ocnt[7:0] === 8'h0 && (s2[3:0] != 4'h8 || ocnt === 16'h0), "final count");
    chk(occr === ccr, "flags");
  endtask
  initial forever #2 clk = ~clk;
  always @(negedge clk) slow <= ~slow;
  always @(posedge clk) if (wr && wa) begin
    chk(wad === ed && wd === (es[7:0] ^ 8'h5a), "write");
    es <= es + 24'h1;
    ed <= ed + 24'h1;
    nw <= nw + 1;
  end
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    run(8'h80, 16'h5500, 0);
    run(8'h88, 16'h0000, 0);
    run(8'h80, 16'h12ff, 255);
    run(8'h88, 16'h0100, 256);
    @(negedge clk);
    op2 = 8'h08;
    start = 1'b1;
    @(negedge clk);
    chk(gh === 1'b0 && cp === 1'b0 && busy === 1'b0, "group");
    op1 = 8'h7a;
    op2 = 8'h88;
    @(negedge clk);
    chk(gh === 1'b1 && cp === 1'b0 && busy === 1'b0, "first byte");
    start = 1'b0;
    op1 = 8'h7b;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      lat = r[1:0];
      run(r[4] ? 8'h88 : 8'h80, {r[4] ? 8'h00 : r[31:24], 4'h0, r[11:8]}, int'(r[11:8]));
    end
    wrap_up();
  end
endmodule
`default_nettype wire
